// [src/amw_pkg.sv]
// amw_pkg: register map, field layout and constants of the async width/wait block
// assumes APB with 32-bit data, one register per aligned word
package amw_pkg;
   localparam int NUM_SPACES = 4;
   localparam logic [11:0] OFF_CFG0 = 12'h000;
   localparam logic [11:0] OFF_CFG1 = 12'h004;
   localparam logic [11:0] OFF_CFG2 = 12'h008;
   localparam logic [11:0] OFF_CFG3 = 12'h00C;
   localparam logic [11:0] OFF_WAIT_CFG = 12'h010;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h014;
   localparam logic [11:0] OFF_IRQ_EN_SET = 12'h018;
   localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h01C;
   localparam logic [11:0] OFF_ACC_STATUS = 12'h020;
   // chip space config fields
   localparam int CFG_WIDTH_BIT = 0;
   localparam int CFG_STROBE_LSB = 4;
   localparam int CFG_STROBE_W = 6;
   localparam int CFG_EXTWAIT_BIT = 30;
   localparam logic [31:0] CFG_RESET = 32'h3FFF_FFFD;
   localparam logic [31:0] CFG_MASK = 32'h4000_03F1;
   // wait config fields
   localparam int WCFG_MAXWAIT_LSB = 0;
   localparam int WCFG_MAXWAIT_W = 8;
   localparam int WCFG_POL_BIT = 28;
   localparam logic [31:0] WCFG_RESET = 32'h1000_0080;
   localparam logic [31:0] WCFG_MASK = 32'h1000_00FF;
   // interrupt bit positions, wait unit shift, counter width and bus width codes
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_WAITRISE_BIT = 2;
   localparam int WAIT_UNIT_SHIFT = 4;
   localparam int CNT_W = 13;
   localparam logic BUS_WIDTH_8 = 1'b0;
   localparam logic BUS_WIDTH_16 = 1'b1;
endpackage

// [src/amw_req_if.sv]
// amw_req_if: one external access between sequencer and wait timer
// assumes a single sys_clk domain
`timescale 1ns/1ns
interface amw_req_if;
   logic start;
   logic [5:0] strobeLen;
   logic extWait;
   logic waitPol;
   logic [7:0] maxWait;
   logic done;
   logic timedOut;
   modport seq (output start, output strobeLen, output extWait, output waitPol,
      output maxWait, input done, input timedOut);
   modport tmr (input start, input strobeLen, input extWait, input waitPol,
      input maxWait, output done, output timedOut);
endinterface

// [src/amw_strobe_timer.sv]
// amw_strobe_timer: times one strobe period, stretched by the wait input
// assumes waitSync is already synchronised to sys_clk
`timescale 1ns/1ns
module amw_strobe_timer (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic waitSync,
   amw_req_if.tmr req
);
   logic busy;
   logic next_busy;
   logic [5:0] baseCnt;
   logic [5:0] next_baseCnt;
   logic [amw_pkg::CNT_W-1:0] waitCnt;
   logic [amw_pkg::CNT_W-1:0] next_waitCnt;
   logic waitActive;
   logic [amw_pkg::CNT_W-1:0] waitLimit;

   assign waitActive = req.extWait && (waitSync == req.waitPol);
   // (max + 1) * 16 cycles
   assign waitLimit = amw_pkg::CNT_W'({5'h00, req.maxWait} + 13'h001)
      << amw_pkg::WAIT_UNIT_SHIFT;

   always_comb begin
      next_busy = busy;
      next_baseCnt = baseCnt;
      next_waitCnt = waitCnt;
      req.done = 1'b0;
      req.timedOut = 1'b0;
      if (!busy) begin
         if (req.start) begin
            next_busy = 1'b1;
            next_baseCnt = req.strobeLen;
            next_waitCnt = '0;
         end
      end else if (baseCnt != 6'h00) begin
         next_baseCnt = baseCnt - 6'h01;
      end else if (waitActive) begin
         if (waitCnt == waitLimit - 13'h0001) begin
            req.done = 1'b1;
            req.timedOut = 1'b1;
            next_busy = 1'b0;
         end else begin
            next_waitCnt = waitCnt + 13'h0001;
         end
      end else begin
         req.done = 1'b1;
         next_busy = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         busy <= 1'b0;
         baseCnt <= '0;
         waitCnt <= '0;
      end else begin
         busy <= next_busy;
         baseCnt <= next_baseCnt;
         waitCnt <= next_waitCnt;
      end
   end

   property p_timeout_bound;
      @(posedge sys_clk) disable iff (reset)
         req.timedOut |-> waitCnt == waitLimit - 13'h0001;
   endproperty
   a_timeout_bound: assert property (p_timeout_bound) else $error("early timeout");

   property p_no_wait_no_timeout;
      @(posedge sys_clk) disable iff (reset)
         (busy && !req.extWait) |-> !req.timedOut;
   endproperty
   a_no_wait_no_timeout: assert property (p_no_wait_no_timeout) else $error("wait not ignored");
endmodule // amw_strobe_timer

// [src/amw_width_wait_ctrl.sv]
// amw_width_wait_ctrl: bus width splitting and extended wait for async memory
// assumes APB slave registers, requester on sys_clk, wait pin asynchronous
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module amw_width_wait_ctrl (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqWrite,
   input wire logic [1:0] reqSpace,
   input wire logic [23:0] reqAddr,
   input wire logic [31:0] reqWdata,
   output logic [31:0] reqRdata,
   output logic reqDone,
   output logic [21:0] addressPins,
   output logic [1:0] bankAddressPins,
   output logic [15:0] memDataOut,
   output logic memDataOe,
   input wire logic [15:0] memDataIn,
   output logic memStrobe,
   output logic memWrite,
   input wire logic waitInput,
   output logic timeoutEvent,
   output logic waitRiseEvent,
   output logic irq
);
   typedef enum logic [1:0] {
      AMW_IDLE = 2'b00,
      AMW_STROBE = 2'b01,
      AMW_HOLD = 2'b10,
      AMW_LOAD = 2'b11
   } amw_state_t;

   logic [31:0] spaceCfg [amw_pkg::NUM_SPACES];
   logic [31:0] next_spaceCfg [amw_pkg::NUM_SPACES];
   logic [31:0] waitCfg;
   logic [31:0] next_waitCfg;
   logic [2:0] irqStatus;
   logic [2:0] next_irqStatus;
   logic [2:0] irqEnable;
   logic [2:0] next_irqEnable;
   logic [31:0] next_prdata;
   amw_state_t state;
   amw_state_t next_state;
   logic [1:0] beat;
   logic [1:0] next_beat;
   logic [1:0] lastBeat;
   logic [1:0] next_lastBeat;
   logic [1:0] space;
   logic [1:0] next_space;
   logic isWrite;
   logic next_isWrite;
   logic [23:0] baseAddr;
   logic [23:0] next_baseAddr;
   logic [31:0] wdata;
   logic [31:0] next_wdata;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic is16;
   logic next_is16;
   logic done;
   logic next_done;
   logic timeoutSeen;
   logic next_timeoutSeen;
   logic [21:0] next_addressPins;
   logic [1:0] next_bankAddressPins;
   logic [15:0] next_memDataOut;
   logic waitMeta;
   logic waitSync;
   logic waitPrev;
   logic apbWr;
   logic apbRd;
   logic [23:0] byteAddr;
   logic [23:0] startAddr;
   amw_req_if req ();

   // index of the last beat for a 32-bit request on the chosen width
   function automatic logic [1:0] amw_last_beat(input logic wide);
      return wide ? 2'h1 : 2'h3;
   endfunction

   // byte address of one beat on the chosen width
   function automatic logic [23:0] byteAddrNext(input logic [23:0] base, input logic [1:0] b,
      input logic wide);
      return base + (wide ? {21'h0, b, 1'b0} : {22'h0, b});
   endfunction

   assign apbWr = psel && penable && pwrite;
   assign apbRd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign reqReady = (state == AMW_IDLE) && !done;
   assign reqDone = done;
   assign reqRdata = rdata;
   assign memStrobe = (state == AMW_STROBE);
   assign memWrite = (state != AMW_IDLE) && isWrite;
   assign memDataOe = (state != AMW_IDLE) && isWrite;
   assign timeoutEvent = req.done && req.timedOut;
   assign waitRiseEvent = waitSync && !waitPrev;
   assign irq = |(irqStatus & irqEnable);

   // wait pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         waitMeta <= 1'b0;
         waitSync <= 1'b0;
         waitPrev <= 1'b0;
      end else begin
         waitMeta <= waitInput;
         waitSync <= waitMeta;
         waitPrev <= waitSync;
      end
   end

   // register file
   always_comb begin
      next_spaceCfg = spaceCfg;
      next_waitCfg = waitCfg;
      next_irqEnable = irqEnable;
      next_irqStatus = irqStatus;
      next_prdata = prdata;
      if (apbWr) begin
         unique case (paddr)
            amw_pkg::OFF_CFG0: next_spaceCfg[0] = pwdata & amw_pkg::CFG_MASK;
            amw_pkg::OFF_CFG1: next_spaceCfg[1] = pwdata & amw_pkg::CFG_MASK;
            amw_pkg::OFF_CFG2: next_spaceCfg[2] = pwdata & amw_pkg::CFG_MASK;
            amw_pkg::OFF_CFG3: next_spaceCfg[3] = pwdata & amw_pkg::CFG_MASK;
            amw_pkg::OFF_WAIT_CFG: next_waitCfg = pwdata & amw_pkg::WCFG_MASK;
            amw_pkg::OFF_IRQ_STATUS: next_irqStatus = irqStatus & ~pwdata[2:0];
            amw_pkg::OFF_IRQ_EN_SET: next_irqEnable = irqEnable | pwdata[2:0];
            amw_pkg::OFF_IRQ_EN_CLR: next_irqEnable = irqEnable & ~pwdata[2:0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      if (timeoutEvent) begin
         next_irqStatus[amw_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
      end
      if (waitRiseEvent) begin
         next_irqStatus[amw_pkg::IRQ_WAITRISE_BIT] = 1'b1;
      end
      if (apbRd) begin
         unique case (paddr)
            amw_pkg::OFF_CFG0: next_prdata = spaceCfg[0];
            amw_pkg::OFF_CFG1: next_prdata = spaceCfg[1];
            amw_pkg::OFF_CFG2: next_prdata = spaceCfg[2];
            amw_pkg::OFF_CFG3: next_prdata = spaceCfg[3];
            amw_pkg::OFF_WAIT_CFG: next_prdata = waitCfg;
            amw_pkg::OFF_IRQ_STATUS: next_prdata = {29'h0, irqStatus};
            amw_pkg::OFF_IRQ_EN_SET: next_prdata = {29'h0, irqEnable};
            amw_pkg::OFF_IRQ_EN_CLR: next_prdata = {29'h0, irqEnable};
            amw_pkg::OFF_ACC_STATUS: next_prdata = {28'h0, timeoutSeen, state == AMW_IDLE,
               state};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < amw_pkg::NUM_SPACES; i++) begin
            spaceCfg[i] <= amw_pkg::CFG_RESET & amw_pkg::CFG_MASK;
         end
         waitCfg <= amw_pkg::WCFG_RESET;
         irqStatus <= '0;
         irqEnable <= '0;
         prdata <= '0;
      end else begin
         spaceCfg <= next_spaceCfg;
         waitCfg <= next_waitCfg;
         irqStatus <= next_irqStatus;
         irqEnable <= next_irqEnable;
         prdata <= next_prdata;
      end
   end

   // byte address of the current beat
   assign byteAddr = byteAddrNext(baseAddr, beat, is16);

   // access sequencer
   always_comb begin
      next_state = state;
      next_beat = beat;
      next_lastBeat = lastBeat;
      next_space = space;
      next_isWrite = isWrite;
      next_baseAddr = baseAddr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_is16 = is16;
      next_done = 1'b0;
      next_timeoutSeen = timeoutSeen;
      next_addressPins = addressPins;
      next_bankAddressPins = bankAddressPins;
      next_memDataOut = memDataOut;
      req.start = 1'b0;
      req.strobeLen = spaceCfg[space][amw_pkg::CFG_STROBE_LSB +: amw_pkg::CFG_STROBE_W];
      req.extWait = spaceCfg[space][amw_pkg::CFG_EXTWAIT_BIT];
      req.waitPol = waitCfg[amw_pkg::WCFG_POL_BIT];
      req.maxWait = waitCfg[amw_pkg::WCFG_MAXWAIT_LSB +: amw_pkg::WCFG_MAXWAIT_W];
      unique case (state)
         AMW_IDLE: begin
            if (reqValid && !done) begin
               next_space = reqSpace;
               next_isWrite = reqWrite;
               next_baseAddr = {reqAddr[23:2], 2'b00};
               next_wdata = reqWdata;
               next_beat = 2'h0;
               next_is16 = spaceCfg[reqSpace][amw_pkg::CFG_WIDTH_BIT];
               next_lastBeat = amw_last_beat(next_is16);
               next_state = AMW_LOAD;
               next_timeoutSeen = 1'b0;
            end
         end
         // first beat: width and address are registered by now
         AMW_LOAD: begin
            next_state = AMW_STROBE;
            req.start = 1'b1;
         end
         AMW_STROBE: begin
            if (req.done) begin
               if (req.timedOut) begin
                  next_timeoutSeen = 1'b1;
               end
               // capture the bus even after a timeout
               if (!isWrite) begin
                  if (is16) begin
                     next_rdata[beat[0]*16 +: 16] = memDataIn;
                  end else begin
                     next_rdata[beat*8 +: 8] = memDataIn[7:0];
                  end
               end
               next_state = AMW_HOLD;
            end
         end
         AMW_HOLD: begin
            if (beat == lastBeat) begin
               next_done = 1'b1;
               next_state = AMW_IDLE;
            end else begin
               next_beat = beat + 2'h1;
               next_state = AMW_STROBE;
               req.start = 1'b1;
            end
         end
      endcase
      // drive pins for the beat about to start
      startAddr = byteAddrNext(baseAddr, next_beat, is16);
      if (req.start) begin
         if (is16) begin
            next_addressPins = {1'b0, startAddr[23:3]};
            next_bankAddressPins = startAddr[2:1];
            next_memDataOut = wdata[next_beat[0]*16 +: 16];
         end else begin
            next_addressPins = startAddr[23:2];
            next_bankAddressPins = startAddr[1:0];
            next_memDataOut = {8'h00, wdata[next_beat*8 +: 8]};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= AMW_IDLE;
         beat <= '0;
         lastBeat <= '0;
         space <= '0;
         isWrite <= 1'b0;
         baseAddr <= '0;
         wdata <= '0;
         rdata <= '0;
         is16 <= amw_pkg::BUS_WIDTH_8;
         done <= 1'b0;
         timeoutSeen <= 1'b0;
         addressPins <= '0;
         bankAddressPins <= '0;
         memDataOut <= '0;
      end else begin
         state <= next_state;
         beat <= next_beat;
         lastBeat <= next_lastBeat;
         space <= next_space;
         isWrite <= next_isWrite;
         baseAddr <= next_baseAddr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         is16 <= next_is16;
         done <= next_done;
         timeoutSeen <= next_timeoutSeen;
         addressPins <= next_addressPins;
         bankAddressPins <= next_bankAddressPins;
         memDataOut <= next_memDataOut;
      end
   end

   amw_strobe_timer timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .waitSync(waitSync),
      .req(req.tmr)
   );

   property p_timeout_to_hold;
      @(posedge sys_clk) disable iff (reset)
         timeoutEvent |=> state == AMW_HOLD;
   endproperty
   a_timeout_to_hold: assert property (p_timeout_to_hold) else $error("no hold after timeout");

   property p_irq_gated;
      @(posedge sys_clk) disable iff (reset)
         (timeoutEvent && !irqEnable[amw_pkg::IRQ_TIMEOUT_BIT] && irqStatus == 3'h0
            && !waitRiseEvent) |=> !irq;
   endproperty
   a_irq_gated: assert property (p_irq_gated) else $error("timeout irq while disabled");

   property p_en_set;
      @(posedge sys_clk) disable iff (reset)
         (apbWr && paddr == amw_pkg::OFF_IRQ_EN_SET) |=> (irqEnable & $past(pwdata[2:0]))
            == $past(pwdata[2:0]);
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable set failed");

   property p_en_keep;
      @(posedge sys_clk) disable iff (reset)
         (apbWr && paddr == amw_pkg::OFF_IRQ_EN_SET) |=> (irqEnable & $past(irqEnable))
            == $past(irqEnable);
   endproperty
   a_en_keep: assert property (p_en_keep) else $error("enable lost on set write");

   property p_en_clr;
      @(posedge sys_clk) disable iff (reset)
         (apbWr && paddr == amw_pkg::OFF_IRQ_EN_CLR) |=> (irqEnable & $past(pwdata[2:0])) == 3'h0;
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("enable clear failed");

   property p_beats;
      @(posedge sys_clk) disable iff (reset)
         (state == AMW_HOLD && beat == lastBeat) |-> lastBeat == (is16 ? 2'h1 : 2'h3);
   endproperty
   a_beats: assert property (p_beats) else $error("wrong beat count");

   property p_addr_map;
      @(posedge sys_clk) disable iff (reset)
         (state == AMW_STROBE && !is16) |-> {addressPins, bankAddressPins} == byteAddr[23:0];
   endproperty
   a_addr_map: assert property (p_addr_map) else $error("8-bit address map wrong");

   property p_wait_stretch;
      @(posedge sys_clk) disable iff (reset)
         (state == AMW_STROBE && req.extWait && waitSync == req.waitPol && !req.done)
            |=> state == AMW_STROBE;
   endproperty
   a_wait_stretch: assert property (p_wait_stretch) else $error("strobe not stretched");
endmodule // amw_width_wait_ctrl

// [tb/amw_mem_model.sv]
// amw_mem_model: byte-addressed async memory, 8 or 16 bits wide, with a wait output for the bench
// assumes the bench sets bus width, wait polarity and wait length per access
`timescale 1ns/1ns
module amw_mem_model (
   input wire logic sys_clk,
   input wire logic [21:0] addressPins,
   input wire logic [1:0] bankAddressPins,
   input wire logic [15:0] memDataOut,
   input wire logic memDataOe,
   output logic [15:0] memDataIn,
   input wire logic memStrobe,
   input wire logic memWrite,
   output logic waitInput,
   input wire logic wide,
   input wire logic waitPol,
   input wire logic [11:0] waitLen
);
   logic [7:0] mem [0:255];
   logic [7:0] ba;
   logic [11:0] cnt = 12'h000;
   logic act = 1'b0;
   initial memDataIn = 16'h0000;
   // byte address rebuilt from the pins as the width maps them
   assign ba = wide ? {addressPins[4:0], bankAddressPins, 1'b0} :
      {addressPins[5:0], bankAddressPins};
   assign waitInput = act ? waitPol : ~waitPol;
   always @(posedge sys_clk) begin
      cnt <= memStrobe ? cnt + 12'h001 : 12'h000;
      act <= memStrobe && (cnt < waitLen);
      if (memStrobe && !memWrite) begin
         memDataIn <= wide ? {mem[ba + 8'h01], mem[ba]} : {~memDataIn[15:8], mem[ba]};
      end else begin
         // released bus: no stale value left standing
         memDataIn <= ~memDataIn;
      end
      if (memStrobe && memWrite && memDataOe) begin
         mem[ba] <= memDataOut[7:0];
         if (wide) mem[ba + 8'h01] <= memDataOut[15:8];
      end
   end
endmodule // amw_mem_model

// [tb/amw_width_wait_ctrl_tb_top.sv]
// amw_width_wait_ctrl_tb_top: register, width and wait checks over APB
// assumes the memory model stands on the external pins
`timescale 1ns/1ns
module amw_width_wait_ctrl_tb_top;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, reqRdata;
   logic pready, pslverr, reqReady, reqDone, memDataOe, memStrobe, memWrite;
   logic reqValid = 1'b0, reqWrite = 1'b0;
   logic [1:0] reqSpace = 2'h0;
   logic [23:0] reqAddr = 24'h000000;
   logic [31:0] reqWdata = 32'h0000_0000;
   logic [21:0] addressPins;
   logic [1:0] bankAddressPins;
   logic [15:0] memDataOut, memDataIn;
   logic waitInput, timeoutEvent, waitRiseEvent, irq;
   logic wide = 1'b0, waitPol = 1'b1;
   logic [11:0] waitLen = 12'h000;
   int err_count = 0, n_compared = 0;
   int beats = 0, stbCyc = 0, nTo = 0, nRise = 0;
   logic prevStb = 1'b0;
   logic [31:0] q, nb, len, base;

   always #2 sys_clk = ~sys_clk;

   amw_width_wait_ctrl dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .reqValid, .reqReady, .reqWrite,
      .reqSpace, .reqAddr, .reqWdata, .reqRdata, .reqDone, .addressPins,
      .bankAddressPins, .memDataOut, .memDataOe, .memDataIn, .memStrobe,
      .memWrite, .waitInput, .timeoutEvent, .waitRiseEvent, .irq);

   amw_mem_model mem (.sys_clk, .addressPins, .bankAddressPins, .memDataOut,
      .memDataOe, .memDataIn, .memStrobe, .memWrite, .waitInput, .wide,
      .waitPol, .waitLen);

   // strobe beats, strobe cycles and event pulses
   always @(posedge sys_clk) begin
      if (memStrobe === 1'b1) stbCyc++;
      if (memStrobe === 1'b1 && prevStb !== 1'b1) beats++;
      prevStb = memStrobe;
      if (timeoutEvent === 1'b1) nTo++;
      if (waitRiseEvent === 1'b1) nRise++;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic xfer(input logic wr, input logic [1:0] sp, input logic [23:0] a,
      input logic [31:0] d);
      int n, b0, s0, t0;
      b0 = beats;
      s0 = stbCyc;
      t0 = nTo;
      @(posedge sys_clk);
      reqValid <= 1'b1;
      reqWrite <= wr;
      reqSpace <= sp;
      reqAddr <= a;
      reqWdata <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (reqReady !== 1'b1 && n < 50);
      reqValid <= 1'b0;
      n = 0;
      while (reqDone !== 1'b1 && n < 5000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 5000) chk("reqDone", 32'h1, 32'h0);
      repeat (2) @(posedge sys_clk);
      q = reqRdata;
      nb = beats - b0;
      len = (nb != 0) ? (stbCyc - s0) / nb : 32'h0;
      nTo = nTo - t0;
   endtask

   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(4 * 40000);
      err_count++;
      stop_test();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      apb(0, amw_pkg::OFF_WAIT_CFG, 32'h0);
      chk("wait_cfg", amw_pkg::WCFG_RESET, q);
      apb(0, 12'h0FC, 32'h0);
      chk("unmapped", 32'h0, q);
      // strobe 4: longer than the wait pin's synchroniser delay
      apb(1, amw_pkg::OFF_CFG0, 32'h0000_0040);
      apb(1, amw_pkg::OFF_CFG1, 32'h0000_0041);
      apb(0, amw_pkg::OFF_CFG1, 32'h0);
      chk("cfg1", 32'h0000_0041, q);
      xfer(1, 2'h0, 24'h000010, 32'hA1B2_C3D4);
      chk("beats8", 32'h4, nb);
      xfer(0, 2'h0, 24'h000010, 32'h0);
      chk("rd8", 32'hA1B2_C3D4, q);
      base = len;
      wide <= 1'b1;
      xfer(0, 2'h1, 24'h000010, 32'h0);
      chk("rd16", 32'hA1B2_C3D4, q);
      chk("beats16", 32'h2, nb);
      xfer(1, 2'h1, 24'h000020, 32'h55AA_1234);
      wide <= 1'b0;
      xfer(0, 2'h0, 24'h000020, 32'h0);
      chk("rd8b", 32'h55AA_1234, q);
      wide <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         apb(1, amw_pkg::OFF_WAIT_CFG, (32'(p) << 28) | 32'h0000_000F);
         waitPol <= p[0];
         waitLen <= 12'h000;
         apb(1, amw_pkg::OFF_CFG1, 32'h4000_0041);
         xfer(0, 2'h1, 24'h000020, 32'h0);
         chk("len_idle", base, len);
         waitLen <= 12'h01E;
         xfer(0, 2'h1, 24'h000020, 32'h0);
         chk("len_wait", 32'h1, 32'(len >= 30 && len <= 38));
         apb(1, amw_pkg::OFF_CFG1, 32'h0000_0041);
         xfer(0, 2'h1, 24'h000020, 32'h0);
         chk("len_noext", base, len);
      end
      apb(1, amw_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF);
      apb(1, amw_pkg::OFF_CFG1, 32'h4000_0041);
      waitLen <= 12'hFFF;
      for (int m = 0; m < 2; m++) begin
         apb(1, amw_pkg::OFF_WAIT_CFG, 32'h1000_0000 | 32'(m));
         xfer(0, 2'h1, 24'h000020, 32'h0);
         chk("to_data", 32'h55AA_1234, q);
         chk("to_count", 32'h2, 32'(nTo));
         // last base strobe cycle already counts as the first waited cycle
         chk("to_len", 32'h1, 32'(len >= base + 16 * (m + 1) - 1 &&
            len <= base + 16 * (m + 1) + 2));
      end
      waitLen <= 12'h000;
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(0, amw_pkg::OFF_IRQ_STATUS, 32'h0);
      chk("to_status", 32'h1, 32'(q[amw_pkg::IRQ_TIMEOUT_BIT]));
      chk("rise_seen", 32'h1, 32'(nRise > 0));
      for (int b = 0; b < 3; b += 2) begin
         apb(1, amw_pkg::OFF_IRQ_EN_SET, 32'h1 << b);
         repeat (2) @(posedge sys_clk);
         chk("irq_on", 32'h1, {31'h0, irq});
         apb(1, amw_pkg::OFF_IRQ_EN_SET, 32'h0);
         apb(0, amw_pkg::OFF_IRQ_EN_SET, 32'h0);
         chk("en_set", 32'h1 << b, q);
         apb(1, amw_pkg::OFF_IRQ_EN_CLR, 32'h1 << b);
         apb(0, amw_pkg::OFF_IRQ_EN_SET, 32'h0);
         chk("en_clr", 32'h0, q);
         repeat (2) @(posedge sys_clk);
         chk("irq_off", 32'h0, {31'h0, irq});
      end
      stop_test();
   end
endmodule // amw_width_wait_ctrl_tb_top
